// file: src/insn_decoder_pkg.sv
// Constants and types for the 14-bit instruction decoder
//
// Functional notes
// - Byte ops: bit 7 chooses accumulator (0) or file register (1)
// - Byte 0111 adds accumulator to file; carry, half carry and zero
// - Byte codes 0100 OR, 0101 AND with file; only zero flag changes
// - Byte code 0110 XORs accumulator with file; only zero flag changes
// - Byte 1101 rotates left, 1100 rotates right through carry; carry only
// - 0011 decrements setting zero; 1011 decrements, skips on zero result
// - 1010 increments setting zero; 1111 increments, skips on zero result
// - Bit group sub-code 00 clears selected bit; no flags
// - Bit group sub-code 01 sets selected bit; no flags
// - Bit sub-code 10 skips next instruction when selected bit is zero
// - Bit sub-code 11 skips next instruction when selected bit is one
// - Literal 111x adds immediate to accumulator; carry, half carry, zero
// - Literal 1000 ORs immediate into accumulator; zero flag only
// - Literal 1010 XORs immediate into accumulator; zero flag only
// - Literal 110x: immediate minus accumulator; carry, half carry, zero
// - Return with literal loads accumulator, returns, takes two cycles
// - Standby word runs one cycle, sets timeout, clears power-down
// - Port reads for modify-write use pin levels, not the latch
// - File writes to timer zero clear its prescaler when assigned
// - Program counter change or true skip takes two cycles
package insn_decoder_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] INSTR_OFS  = 8'h04;
  localparam logic [7:0] OPND_OFS   = 8'h08;
  localparam logic [7:0] ACC_OFS    = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] RESULT_OFS = 8'h14;

  // Status field positions
  localparam int C_BIT          = 0;
  localparam int HALF_CARRY_BIT = 1;
  localparam int Z_BIT          = 2;
  localparam int POWER_DOWN_BIT = 3;
  localparam int TIMEOUT_BIT    = 4;

  // Result field positions
  localparam int RES_FWE   = 15;
  localparam int RES_AWE   = 16;
  localparam int RES_SKIP  = 17;
  localparam int RES_TWO   = 18;
  localparam int RES_BUSY  = 19;

  // Reset values
  localparam logic [4:0]  STATUS_RST = 5'h18;
  localparam logic [13:0] INSTR_RST  = 14'h0000;

  // File addresses with side effects
  localparam logic [6:0] TIMER_ADDR = 7'h01;
  localparam logic [6:0] PORT_ADDR  = 7'h05;

  // Group prefixes and fixed control words
  localparam logic [1:0]  GRP_BYTE = 2'h0;
  localparam logic [1:0]  GRP_BIT  = 2'h1;
  localparam logic [1:0]  GRP_JUMP = 2'h2;
  localparam logic [13:0] W_IRQRET = 14'h0009;
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_KICK   = 14'h0064;
  localparam logic [13:0] W_SLEEP  = 14'h0063;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_EXEC   = 3'b010,
    ST_SECOND = 3'b100
  } exec_state_t;

  typedef struct packed {
    logic [7:0] result;
    logic       fileWe;
    logic       accWe;
    logic       updC;
    logic       updHc;
    logic       updZ;
    logic       carry;
    logic       halfCarry;
    logic       skip;
    logic       pcLoad;
    logic       retReq;
    logic       standby;
    logic       kick;
  } decode_t;

endpackage

// file: src/insn_decoder.sv
// Instruction decoder and executor with an APB register port
`timescale 1ns/10ps
module insn_decoder
  import insn_decoder_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Port pin levels
  input  wire logic [7:0]  portPins,
  // File register write-back
  output logic             fileWe,
  output logic [6:0]       fileAddr,
  output logic [7:0]       fileData,
  // Side effects
  output logic             prescalerClr,
  output logic             standbyReq,
  output logic             watchdogKick,
  output logic             pcLoad,
  output logic [10:0]      pcTarget,
  output logic             returnReq
);

  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  pinS1_ff;
  logic [7:0]  pinS2_ff;
  logic [7:0]  pinS3_ff;
  logic [7:0]  pinStable_ff;
  logic        prescToTimer_ff;
  logic [13:0] instr_ff;
  logic [7:0]  opnd_ff;
  logic [7:0]  acc_ff;
  logic [4:0]  status_ff;
  logic [7:0]  lastRes_ff;
  logic        lastFwe_ff;
  logic        lastAwe_ff;
  logic        lastSkip_ff;
  logic        lastTwo_ff;
  exec_state_t state_ff;
  exec_state_t nxt_state;
  logic        fileWe_ff;
  logic [6:0]  fileAddr_ff;
  logic [7:0]  fileData_ff;
  logic        prescalerClr_ff;
  logic        standby_ff;
  logic        kick_ff;
  logic        pcLoad_ff;
  logic [10:0] pcTarget_ff;
  logic        returnReq_ff;

  logic        setupPh;
  logic        wrDone;
  logic        busy;
  logic [31:0] rdVal;
  logic        mapped;
  decode_t     dec;
  logic        twoCycle;
  logic        execNow;

  assign setupPh = psel && !penable;
  assign wrDone  = psel && penable && pready_ff && pwrite;
  assign busy    = (state_ff != ST_IDLE);
  assign execNow = (state_ff == ST_EXEC);

  // Pin synchroniser; a level counts once the last two stages agree
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pinS1_ff     <= 8'h00;
      pinS2_ff     <= 8'h00;
      pinS3_ff     <= 8'h00;
      pinStable_ff <= 8'h00;
    end
    else
    begin
      pinS1_ff <= portPins;
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      for (int i = 0; i < 8; i++)
      begin
        if (pinS2_ff[i] == pinS3_ff[i])
          pinStable_ff[i] <= pinS3_ff[i];
      end
    end
  end

  // Read mux and address decode
  always_comb
  begin
    rdVal  = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == CTRL_OFS)
      rdVal = {31'h0000_0000, prescToTimer_ff};
    else if (paddr == INSTR_OFS)
      rdVal = {18'h00000, instr_ff};
    else if (paddr == OPND_OFS)
      rdVal = {24'h000000, opnd_ff};
    else if (paddr == ACC_OFS)
      rdVal = {24'h000000, acc_ff};
    else if (paddr == STATUS_OFS)
      rdVal = {27'h0000000, status_ff};
    else if (paddr == RESULT_OFS)
      rdVal = {12'h000, busy, lastTwo_ff, lastSkip_ff, lastAwe_ff,
               lastFwe_ff, instr_ff[6:0], lastRes_ff};
    else
      mapped = 1'b0;
  end

  // APB answer: ready one cycle after setup, no wait states
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= setupPh;
      pslverr_ff <= setupPh && !mapped;
      if (setupPh)
        prdata_ff <= rdVal;
    end
  end

  // Software-held control and operand registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prescToTimer_ff <= 1'b0;
      instr_ff        <= INSTR_RST;
      opnd_ff         <= 8'h00;
    end
    else if (wrDone)
    begin
      if (paddr == CTRL_OFS)
        prescToTimer_ff <= pwdata[0];
      else if (paddr == INSTR_OFS && !busy)
        instr_ff <= pwdata[13:0];
      else if (paddr == OPND_OFS)
        opnd_ff <= pwdata[7:0];
    end
  end

  function automatic logic [9:0] addFlags(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {h[4], s};
  endfunction

  // Decode of the held instruction word
  always_comb
  begin
    logic [7:0] f;
    logic [7:0] w;
    logic [7:0] k;
    logic [9:0] ar;
    logic [7:0] bm;
    logic       dst;
    f   = opnd_ff;
    w   = acc_ff;
    k   = instr_ff[7:0];
    dst = instr_ff[7];
    bm  = 8'h01 << instr_ff[9:7];
    ar  = 10'h000;
    dec = '0;
    // Port uses pin levels
    // pins replace latch
    if (instr_ff[6:0] == PORT_ADDR)
      f = pinStable_ff;
    case (instr_ff[13:12])
      GRP_BYTE:
      begin
        dec.fileWe = dst;
        dec.accWe  = !dst;
        dec.updZ   = 1'b1;
        case (instr_ff[11:8])
          4'h7:
          begin
            ar = addFlags(w, f, 1'b0);
            dec.result = ar[7:0];
            {dec.updC, dec.updHc} = 2'b11;
            {dec.halfCarry, dec.carry} = {ar[9], ar[8]};
          end
          4'h2:
          begin
            ar = addFlags(f, ~w, 1'b1);
            dec.result = ar[7:0];
            {dec.updC, dec.updHc} = 2'b11;
            {dec.halfCarry, dec.carry} = {ar[9], ar[8]};
          end
          4'h4: dec.result = w | f;
          4'h5: dec.result = w & f;
          4'h6: dec.result = w ^ f;
          4'hd:
          begin
            dec.result = {f[6:0], status_ff[C_BIT]};
            {dec.updZ, dec.updC, dec.carry} = {1'b0, 1'b1, f[7]};
          end
          4'hc:
          begin
            dec.result = {status_ff[C_BIT], f[7:1]};
            {dec.updZ, dec.updC, dec.carry} = {1'b0, 1'b1, f[0]};
          end
          4'h3: dec.result = f - 8'h01;
          4'hb:
          begin
            dec.result = f - 8'h01;
            dec.updZ   = 1'b0;
            dec.skip   = (dec.result == 8'h00);
          end
          4'ha: dec.result = f + 8'h01;
          4'hf:
          begin
            dec.result = f + 8'h01;
            dec.updZ   = 1'b0;
            dec.skip   = (dec.result == 8'h00);
          end
          4'h9: dec.result = ~f;
          4'h8: dec.result = f;
          4'he:
          begin
            dec.result = {f[3:0], f[7:4]};
            dec.updZ   = 1'b0;
          end
          4'h1: dec.result = 8'h00;
          default:
          begin
            dec.result = w;
            dec.updZ   = 1'b0;
            dec.accWe  = 1'b0;
            if (instr_ff == W_RETURN || instr_ff == W_IRQRET)
            begin
              dec.retReq = 1'b1;
              dec.pcLoad = 1'b1;
            end
            else if (instr_ff == W_KICK)
              dec.kick = 1'b1;
            else if (instr_ff == W_SLEEP)
              dec.standby = 1'b1;
          end
        endcase
      end
      GRP_BIT:
      begin
        dec.result = f;
        case (instr_ff[11:10])
          2'h0:
          begin
            dec.result = f & ~bm;
            dec.fileWe = 1'b1;
          end
          2'h1:
          begin
            dec.result = f | bm;
            dec.fileWe = 1'b1;
          end
          2'h2: dec.skip = ((f & bm) == 8'h00);
          default: dec.skip = ((f & bm) != 8'h00);
        endcase
      end
      GRP_JUMP:
      begin
        dec.result = w;
        dec.pcLoad = 1'b1;
      end
      default:
      begin
        dec.accWe = 1'b1;
        dec.updZ  = 1'b1;
        casez (instr_ff[11:8])
          4'b111?:
          begin
            ar = addFlags(w, k, 1'b0);
            dec.result = ar[7:0];
            {dec.updC, dec.updHc} = 2'b11;
            {dec.halfCarry, dec.carry} = {ar[9], ar[8]};
          end
          4'b110?:
          begin
            ar = addFlags(k, ~w, 1'b1);
            dec.result = ar[7:0];
            {dec.updC, dec.updHc} = 2'b11;
            {dec.halfCarry, dec.carry} = {ar[9], ar[8]};
          end
          4'b1000: dec.result = w | k;
          4'b1010: dec.result = w ^ k;
          4'b1001: dec.result = w & k;
          4'b01??:
          begin
            dec.result = k;
            dec.updZ   = 1'b0;
            dec.retReq = 1'b1;
            dec.pcLoad = 1'b1;
          end
          default:
          begin
            dec.result = k;
            dec.updZ   = 1'b0;
          end
        endcase
      end
    endcase
  end

  assign twoCycle = dec.pcLoad || dec.skip;

  // Execution sequencer; a second cycle executes nothing but keeps busy set, so instruction writes are dropped
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (wrDone && paddr == INSTR_OFS)
          nxt_state = ST_EXEC;
      ST_EXEC:
        nxt_state = twoCycle ? ST_SECOND : ST_IDLE;
      ST_SECOND:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Accumulator; executes override software writes in the same cycle
  always_ff @(posedge clock)
  begin
    if (reset)
      acc_ff <= 8'h00;
    else if (execNow && dec.accWe)
      acc_ff <= dec.result;
    else if (wrDone && paddr == ACC_OFS)
      acc_ff <= pwdata[7:0];
  end

  // Status flags; hardware update wins over a software write
  always_ff @(posedge clock)
  begin
    if (reset)
      status_ff <= STATUS_RST;
    else if (execNow)
    begin
      if (dec.updC)
        status_ff[C_BIT] <= dec.carry;
      if (dec.updHc)
        status_ff[HALF_CARRY_BIT] <= dec.halfCarry;
      if (dec.updZ)
        status_ff[Z_BIT] <= (dec.result == 8'h00);
      if (dec.standby)
        {status_ff[TIMEOUT_BIT], status_ff[POWER_DOWN_BIT]} <= 2'b10;
      if (dec.kick)
        {status_ff[TIMEOUT_BIT], status_ff[POWER_DOWN_BIT]} <= 2'b11;
    end
    else if (wrDone && paddr == STATUS_OFS)
      status_ff <= pwdata[4:0];
  end

  // Last decode summary for software
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      lastRes_ff  <= 8'h00;
      lastFwe_ff  <= 1'b0;
      lastAwe_ff  <= 1'b0;
      lastSkip_ff <= 1'b0;
      lastTwo_ff  <= 1'b0;
    end
    else if (execNow)
    begin
      lastRes_ff  <= dec.result;
      lastFwe_ff  <= dec.fileWe;
      lastAwe_ff  <= dec.accWe;
      lastSkip_ff <= dec.skip;
      lastTwo_ff  <= twoCycle;
    end
  end

  // One-cycle side-effect pulses toward the core
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      fileWe_ff       <= 1'b0;
      fileAddr_ff     <= 7'h00;
      fileData_ff     <= 8'h00;
      prescalerClr_ff <= 1'b0;
      standby_ff      <= 1'b0;
      kick_ff         <= 1'b0;
      pcLoad_ff       <= 1'b0;
      pcTarget_ff     <= 11'h000;
      returnReq_ff    <= 1'b0;
    end
    else
    begin
      fileWe_ff    <= execNow && dec.fileWe;
      standby_ff   <= execNow && dec.standby;
      kick_ff      <= execNow && dec.kick;
      pcLoad_ff    <= execNow && dec.pcLoad;
      returnReq_ff <= execNow && dec.retReq;
      prescalerClr_ff <= execNow && dec.fileWe && prescToTimer_ff
                         && instr_ff[6:0] == TIMER_ADDR;
      if (execNow)
      begin
        fileAddr_ff <= instr_ff[6:0];
        fileData_ff <= dec.result;
        pcTarget_ff <= instr_ff[10:0];
      end
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign fileWe       = fileWe_ff;
  assign fileAddr     = fileAddr_ff;
  assign fileData     = fileData_ff;
  assign prescalerClr = prescalerClr_ff;
  assign standbyReq   = standby_ff;
  assign watchdogKick = kick_ff;
  assign pcLoad       = pcLoad_ff;
  assign pcTarget     = pcTarget_ff;
  assign returnReq    = returnReq_ff;

endmodule

// file: testbench/insn_decoder_asserts.sv
// Port-level checks for the instruction decoder
`timescale 1ns/10ps
module insn_decoder_asserts
  import insn_decoder_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Execution outputs
  input wire logic        fileWe,
  input wire logic [6:0]  fileAddr,
  input wire logic [7:0]  fileData,
  input wire logic        prescalerClr,
  input wire logic        standbyReq,
  input wire logic        watchdogKick,
  input wire logic        pcLoad,
  input wire logic [10:0] pcTarget,
  input wire logic        returnReq
);
  logic        instrWr;
  logic [13:0] word_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  assign instrWr = psel & penable & pready & pwrite & (paddr == INSTR_OFS);

  // Each write needs its own APB setup cycle, so the capture stays valid for two edges
  always_ff @(posedge clock)
  begin
    if (instrWr)
      word_ff <= pwdata[13:0];
  end

  answer_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  dest_file_a: assert property (
    instrWr && pwdata[13:12] == GRP_BYTE && pwdata[7]
    |-> ##2 fileWe && fileAddr == word_ff[6:0])
    else $error("file destination not written");
  dest_acc_a: assert property (
    instrWr && pwdata[13:12] == GRP_BYTE && !pwdata[7] |-> ##2 !fileWe)
    else $error("file written with accumulator destination");
  bit_clear_a: assert property (
    instrWr && pwdata[13:10] == 4'h4
    |-> ##2 fileWe && !fileData[word_ff[9:7]])
    else $error("selected bit not cleared");
  bit_set_a: assert property (
    instrWr && pwdata[13:10] == 4'h5
    |-> ##2 fileWe && fileData[word_ff[9:7]])
    else $error("selected bit not set");
  bit_test_a: assert property (
    instrWr && pwdata[13:11] == 3'h3 |-> ##2 !fileWe)
    else $error("bit test wrote the file");
  ret_literal_a: assert property (
    instrWr && pwdata[13:10] == 4'hd |-> ##2 pcLoad && returnReq)
    else $error("return with literal did not return");
  standby_pulse_a: assert property (
    instrWr && pwdata[13:0] == W_SLEEP |-> ##2 standbyReq ##1 !standbyReq)
    else $error("standby request missing or long");
  jump_target_a: assert property (
    instrWr && pwdata[13:12] == GRP_JUMP
    |-> ##2 pcLoad && pcTarget == word_ff[10:0])
    else $error("jump target wrong");
  kick_pulse_a: assert property (
    instrWr && pwdata[13:0] == W_KICK |-> ##2 watchdogKick)
    else $error("watchdog kick missing");
  prescale_cause_a: assert property (
    prescalerClr |-> fileWe && fileAddr == TIMER_ADDR)
    else $error("prescaler cleared without timer write");

  cover property (instrWr ##2 fileWe);
  cover property (standbyReq);
  cover property (pcLoad && returnReq);
endmodule

bind insn_decoder insn_decoder_asserts insn_decoder_asserts_inst (
  .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .fileWe, .fileAddr, .fileData, .prescalerClr, .standbyReq,
  .watchdogKick, .pcLoad, .pcTarget, .returnReq
);

// file: testbench/insn_rom.sv
// Program store model handing instruction words to the bench
`timescale 1ns/10ps
module insn_rom
(
  // Word index
  input wire logic [4:0] idx,
  // Instruction word
  output logic [13:0]    word
);
  // Unused slots read as idle so a stray index does no harm
  always_comb
  begin
    case (idx)
      5'h00: word = 14'h07a0;
      5'h01: word = 14'h0720;
      5'h02: word = 14'h04a0;
      5'h03: word = 14'h0520;
      5'h04: word = 14'h06a0;
      5'h05: word = 14'h0da0;
      5'h06: word = 14'h0ca0;
      5'h07: word = 14'h03a0;
      5'h08: word = 14'h0ba0;
      5'h09: word = 14'h0aa0;
      5'h0a: word = 14'h0fa0;
      5'h0b: word = 14'h13a0;
      5'h0c: word = 14'h1420;
      5'h0d: word = 14'h19a0;
      5'h0e: word = 14'h1da0;
      5'h0f: word = 14'h3e01;
      5'h10: word = 14'h38f0;
      5'h11: word = 14'h3aff;
      5'h12: word = 14'h3c05;
      5'h13: word = 14'h3442;
      5'h14: word = 14'h0063;
      5'h15: word = 14'h0064;
      5'h16: word = 14'h0885;
      5'h17: word = 14'h0081;
      5'h18: word = 14'h2abc;
      5'h19: word = 14'h02a0;
      default: word = 14'h0000;
    endcase
  end
endmodule

// file: testbench/tb_insn_decoder.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
module tb_insn_decoder;
  import insn_decoder_pkg::*;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [4:0] stIn;
    logic [7:0] res;
    logic       chk;
    logic [3:0] flg;
    logic [4:0] stOut;
  } vec_t;

  logic        clock, reset, psel, penable, pwrite, pready, pslverr;
  logic        fileWe, prescalerClr, standbyReq, watchdogKick;
  logic        pcLoad, returnReq, e;
  logic [7:0]  paddr, portPins, fileData;
  logic [31:0] pwdata, prdata, q;
  logic [6:0]  fileAddr;
  logic [10:0] pcTarget;
  logic [4:0]  romIdx;
  logic [13:0] romWord;
  int          miscompares, checked, cycles, clrSeen;

  vec_t vecs [26] = '{
    '{8'h0f, 8'h01, 5'h18, 8'h10, 1'b1, 4'h1, 5'h1a},
    '{8'h80, 8'h80, 5'h18, 8'h00, 1'b1, 4'h2, 5'h1d},
    '{8'hf0, 8'h0f, 5'h1f, 8'hff, 1'b1, 4'h1, 5'h1b},
    '{8'hf0, 8'h0f, 5'h18, 8'h00, 1'b1, 4'h2, 5'h1c},
    '{8'h55, 8'h55, 5'h1b, 8'h00, 1'b1, 4'h1, 5'h1f},
    '{8'h00, 8'h81, 5'h1c, 8'h02, 1'b1, 4'h1, 5'h1d},
    '{8'h00, 8'h01, 5'h19, 8'h80, 1'b1, 4'h1, 5'h19},
    '{8'h00, 8'h01, 5'h18, 8'h00, 1'b1, 4'h1, 5'h1c},
    '{8'h00, 8'h01, 5'h18, 8'h00, 1'b1, 4'hd, 5'h18},
    '{8'h00, 8'hff, 5'h18, 8'h00, 1'b1, 4'h1, 5'h1c},
    '{8'h00, 8'hfe, 5'h18, 8'hff, 1'b1, 4'h1, 5'h18},
    '{8'h00, 8'hff, 5'h18, 8'h7f, 1'b1, 4'h1, 5'h18},
    '{8'h00, 8'h00, 5'h18, 8'h01, 1'b1, 4'h1, 5'h18},
    '{8'h00, 8'h00, 5'h18, 8'h00, 1'b0, 4'hc, 5'h18},
    '{8'h00, 8'h08, 5'h18, 8'h00, 1'b0, 4'hc, 5'h18},
    '{8'hff, 8'h00, 5'h18, 8'h00, 1'b1, 4'h2, 5'h1f},
    '{8'h0f, 8'h00, 5'h1c, 8'hff, 1'b1, 4'h2, 5'h18},
    '{8'hff, 8'h00, 5'h18, 8'h00, 1'b1, 4'h2, 5'h1c},
    '{8'h06, 8'h00, 5'h1f, 8'hff, 1'b1, 4'h2, 5'h18},
    '{8'h00, 8'h00, 5'h18, 8'h42, 1'b1, 4'ha, 5'h18},
    '{8'h00, 8'h00, 5'h18, 8'h00, 1'b0, 4'h0, 5'h10},
    '{8'h00, 8'h00, 5'h10, 8'h00, 1'b0, 4'h0, 5'h18},
    '{8'h00, 8'haa, 5'h18, 8'h3c, 1'b1, 4'h1, 5'h18},
    '{8'h5a, 8'h00, 5'h18, 8'h5a, 1'b1, 4'h1, 5'h18},
    '{8'h00, 8'h00, 5'h18, 8'h00, 1'b0, 4'h8, 5'h18},
    '{8'h01, 8'h03, 5'h18, 8'h02, 1'b1, 4'h1, 5'h1b}
  };

  insn_decoder insn_decoder_inst (
    .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .portPins, .fileWe, .fileAddr, .fileData,
    .prescalerClr, .standbyReq, .watchdogKick, .pcLoad, .pcTarget,
    .returnReq
  );

  insn_rom insn_rom_inst (.idx(romIdx), .word(romWord));

  always #2 clock = ~clock;

  task automatic report_and_stop();
    $display("Counts: %0d mismatches, %0d checks", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic fail(input string m);
    miscompares++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  // Request held until ready is seen at an edge, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // Only the bench timeout ends a wait for ready
    while (pready !== 1'b1)
      @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic run_vec(input int i);
    vec_t v;
    v = vecs[i];
    romIdx <= i[4:0];
    apb(1'b1, ACC_OFS, {24'h0, v.acc});
    apb(1'b1, OPND_OFS, {24'h0, v.opnd});
    apb(1'b1, STATUS_OFS, {27'h0, v.stIn});
    apb(1'b1, INSTR_OFS, {18'h0, romWord});
    q = 32'hffffffff;
    // Busy polled, since a word written while busy is dropped silently
    while (q[RES_BUSY] !== 1'b0)
      apb(1'b0, RESULT_OFS, 32'h0);
    checked++;
    if (v.chk && q[7:0] !== v.res)
      fail($sformatf("vec %0d result", i));
    checked++;
    if (q[RES_TWO:RES_FWE] !== v.flg)
      fail($sformatf("vec %0d flags", i));
    apb(1'b0, STATUS_OFS, 32'h0);
    checked++;
    if (q[4:0] !== v.stOut) fail($sformatf("vec %0d status", i));
    if (v.flg[1])
    begin
      apb(1'b0, ACC_OFS, 32'h0);
      checked++;
      if (q[7:0] !== v.res) fail($sformatf("vec %0d acc", i));
    end
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (prescalerClr === 1'b1)
      clrSeen <= clrSeen + 1;
    if (cycles == 6000)
    begin
      fail("timeout");
      report_and_stop();
    end
  end

  initial
  begin
    clock = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    portPins = 8'h3c;
    romIdx = 5'h00;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    apb(1'b0, STATUS_OFS, 32'h0);
    checked++;
    if (q[4:0] !== STATUS_RST) fail("status reset value");
    apb(1'b0, 8'h40, 32'h0);
    checked++;
    if (e !== 1'b1 || q !== 32'h0) fail("unmapped read");
    apb(1'b1, CTRL_OFS, 32'h1);
    for (int i = 0; i < 26; i++)
      run_vec(i);
    checked++;
    if (clrSeen != 1) fail("prescaler clear count");
    report_and_stop();
  end
endmodule
